// ==== core/msj_input_select.sv ====
// terminal conditioning, multispeed selection and jog sequencing
//
// Contract
// - normally-open terminal: signal on while contact closed, off while open.
// - normally-closed terminal: signal on while contact open, off while closed.
// - eight terminal polarity bits plus a separate forward-run polarity bit.
// - fault-reset terminals always read normally-open, ignoring polarity.
// - mode setting picks binary sixteen speeds (00) or bit eight speeds (01).
// - binary mode: four selection inputs, function codes 02..05, pick speeds 0..15.
// - binary speeds 1..15 output the fifteen per-speed frequencies.
// - speed 0 uses panel setting or analog sum, by frequency source.
// - binary combination accepted only after stable for the settle delay.
// - bit mode: seven inputs, function codes 32..38, pick speeds 0..7.
// - bit speeds 1..7 output the first seven per-speed frequencies.
// - bit mode: all off gives speed 0, lowest asserted input wins.
// - terminal source, reversible analog, negative sum: reverse commanded rotation.
// - jog input is any terminal with function code 06.
// - jog outputs jog frequency, limited to 9.99 Hz.
// - stop-mode code: 00-02 no jog while running, 03-05 yes; free/decel/DC.
// - modes 00-02: no jog if forward-run came before jog.
// - modes 03-05: jog anyway; jog released first makes motor coast.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "msj_defs.svh"

module msj_input_select
  import msj_pkg::*;
#(
  parameter int TICK_CYCLES = `MSJ_SETTLE_UNIT_NS / `MSJ_CLK_NS
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [5:0]        ADDR_I,
  input  wire logic [15:0]       WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [15:0]       RDATA_O,
  input  wire logic [7:0]        TERM_CLOSED_I,
  input  wire logic              FWD_CLOSED_I,
  input  wire logic              REV_RUN_I,
  input  wire logic              MOTOR_RUNNING_I,
  input  wire logic signed [15:0] ANALOG_MAIN_I,
  input  wire logic signed [15:0] ANALOG_AUX_I,
  output logic      [15:0]       FREQ_REF_O,
  output logic                   RUN_O,
  output logic                   REVERSE_O,
  output logic                   JOG_ACTIVE_O,
  output logic      [1:0]        STOP_METHOD_O,
  output logic                   FAULT_RESET_O,
  output logic      [3:0]        SPEED_IDX_O
);

  msj_state_s r;
  msj_state_s next_r;

  // ------------------------------------------------------------------
  // terminal conditioning
  // ------------------------------------------------------------------
  logic [7:0] term_sig;
  logic       fwd_sig;
  logic       run_cmd;
  logic       jog_sig;
  logic       frst_sig;
  logic [3:0] bin_raw;
  logic [6:0] bit_raw;

  always_comb begin
    // xor: polarity bit 0 passes the contact, 1 inverts it
    term_sig = TERM_CLOSED_I ^ r.pol[7:0];
    fwd_sig  = FWD_CLOSED_I ^ r.pol[`MSJ_POL_FWD];
    run_cmd  = fwd_sig | REV_RUN_I;
    jog_sig  = 1'b0;
    frst_sig = 1'b0;
    bin_raw  = 4'h0;
    bit_raw  = 7'h00;
    for (int t = 0; t < 8; t++) begin
      if (r.fn[t] == `MSJ_FN_JOG) begin
        jog_sig = jog_sig | term_sig[t];
      end
      if (r.fn[t] == `MSJ_FN_FRST) begin
        frst_sig = frst_sig | TERM_CLOSED_I[t];
      end
      for (int k = 0; k < 4; k++) begin
        if (r.fn[t] == `MSJ_FN_BIN_SEL0 + 8'(k)) begin
          bin_raw[k] = bin_raw[k] | term_sig[t];
        end
      end
      for (int k = 0; k < 7; k++) begin
        if (r.fn[t] == `MSJ_FN_BIT_SEL1 + 8'(k)) begin
          bit_raw[k] = bit_raw[k] | term_sig[t];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // speed selection
  // ------------------------------------------------------------------
  logic [3:0]         bit_idx;
  logic [3:0]         spd_idx;
  logic signed [16:0] ana_sum;
  logic [16:0]        ana_mag;
  logic               ana_rev;
  logic [15:0]        spd0_freq;
  logic [15:0]        ms_freq;

  always_comb begin
    bit_idx = 4'h0;
    // scan downward so the lowest asserted input is written last
    for (int k = 6; k >= 0; k--) begin
      if (bit_raw[k]) begin
        bit_idx = 4'(k + 1);
      end
    end
    spd_idx = (r.mode == `MSJ_MODE_BIT) ? bit_idx : r.bin_sel;
    ana_sum = 17'(ANALOG_MAIN_I) + 17'(ANALOG_AUX_I);
    ana_mag = ana_sum[16] ? 17'(-ana_sum) : 17'(ana_sum);
    ana_rev = r.src_term & r.rev_ok & ana_sum[16];
    if (!r.src_term) begin
      spd0_freq = r.spd0;
    end else if (ana_mag > `MSJ_FREQ_MAX) begin
      spd0_freq = 16'hFFFF;
    end else begin
      spd0_freq = ana_mag[15:0];
    end
    if (spd_idx == 4'h0) begin
      ms_freq = spd0_freq;
    end else begin
      ms_freq = r.spd[spd_idx - 4'h1];
    end
  end

  // ------------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------------
  logic [15:0] rd_val;

  always_comb begin
    rd_val = 16'h0000;
    case (ADDR_I)
      `MSJ_A_CTRL:   rd_val = {13'h0, r.rev_ok, r.src_term, r.mode};
      `MSJ_A_POL:    rd_val = {7'h00, r.pol};
      `MSJ_A_SETTLE: rd_val = r.settle;
      `MSJ_A_JOGF:   rd_val = r.jog_freq;
      `MSJ_A_JSM:    rd_val = {13'h0, r.jsm};
      `MSJ_A_SPD0:   rd_val = r.spd0;
      `MSJ_A_STAT:   rd_val = {2'h0, r.bin_sel, r.spd_idx, r.stop, r.jog, r.rev, r.run, r.frst};
      `MSJ_A_FREQ:   rd_val = r.freq;
      default: begin
        if (ADDR_I[5:3] == `MSJ_A_FN_HI) begin
          rd_val = {8'h00, r.fn[ADDR_I[2:0]]};
        end else if (ADDR_I[5:4] == `MSJ_A_SPD_HI && ADDR_I[3:0] != 4'h0) begin
          rd_val = r.spd[ADDR_I[3:0] - 4'h1];
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic      jog_run_ok;
  msj_stop_e jog_stop;

  always_comb begin
    next_r = r;

    // register writes
    if (WR_I) begin
      case (ADDR_I)
        `MSJ_A_CTRL: begin
          next_r.mode     = WDATA_I[`MSJ_CTRL_MODE];
          next_r.src_term = WDATA_I[`MSJ_CTRL_SRC];
          next_r.rev_ok   = WDATA_I[`MSJ_CTRL_REVOK];
        end
        `MSJ_A_POL:    next_r.pol = WDATA_I[8:0];
        `MSJ_A_SETTLE: next_r.settle = WDATA_I;
        // clamp keeps jog at or below the 9.99 Hz ceiling
        `MSJ_A_JOGF: begin
          next_r.jog_freq = (WDATA_I > `MSJ_JOG_MAX) ? `MSJ_JOG_MAX : WDATA_I;
        end
        `MSJ_A_JSM:    next_r.jsm = WDATA_I[2:0];
        `MSJ_A_SPD0:   next_r.spd0 = WDATA_I;
        default: begin
          if (ADDR_I[5:3] == `MSJ_A_FN_HI) begin
            next_r.fn[ADDR_I[2:0]] = WDATA_I[7:0];
          end else if (ADDR_I[5:4] == `MSJ_A_SPD_HI && ADDR_I[3:0] != 4'h0) begin
            next_r.spd[ADDR_I[3:0] - 4'h1] = WDATA_I;
          end
        end
      endcase
    end
    next_r.rdata = RD_I ? rd_val : 16'h0000;

    // settle time base, one pulse per delay unit
    if (r.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = 16'h0000;
      next_r.tick     = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 16'h0001;
      next_r.tick     = 1'b0;
    end

    // binary combination must hold still before it is taken
    if (bin_raw != r.bin_cand) begin
      next_r.bin_cand   = bin_raw;
      next_r.settle_cnt = 16'h0000;
    end else if (r.settle_cnt >= r.settle) begin
      next_r.bin_sel = r.bin_cand;
    end else if (r.tick) begin
      next_r.settle_cnt = r.settle_cnt + 16'h0001;
    end

    // jog sequencing
    jog_run_ok = (r.jsm >= `MSJ_JSM_RUN_OK) && (r.jsm <= `MSJ_JSM_MAX);
    case (r.jsm)
      3'h0, 3'h3: jog_stop = STOP_FREE;
      3'h1, 3'h4: jog_stop = STOP_DECEL;
      3'h2, 3'h5: jog_stop = STOP_DCB;
      default:    jog_stop = STOP_FREE;
    endcase

    case (r.st)
      ST_IDLE: begin
        if (run_cmd && jog_sig) begin
          next_r.st = ST_JOG;
        end else if (run_cmd) begin
          next_r.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_cmd) begin
          next_r.st   = ST_IDLE;
          next_r.stop = STOP_DECEL;
        end else if (jog_sig && jog_run_ok) begin
          next_r.st = ST_JOG;
        end
        // modes 00-02 keep running at the selected speed: no jog
      end
      ST_JOG: begin
        if (!run_cmd) begin
          next_r.st   = ST_IDLE;
          next_r.stop = jog_stop;
        end else if (!jog_sig) begin
          // run drops and the state locks until the command is released
          next_r.st   = ST_LOCK;
          next_r.stop = jog_run_ok ? STOP_FREE : jog_stop;
        end
      end
      ST_LOCK: begin
        if (!run_cmd) begin
          next_r.st = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // outputs, all registered
    next_r.run     = (next_r.st == ST_RUN) || (next_r.st == ST_JOG);
    next_r.jog     = (next_r.st == ST_JOG);
    next_r.rev     = REV_RUN_I ^ ana_rev;
    next_r.freq    = next_r.jog ? r.jog_freq : ms_freq;
    next_r.frst    = frst_sig;
    next_r.spd_idx = spd_idx;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r.mode       <= `MSJ_MODE_BINARY;
      r.src_term   <= 1'b0;
      r.rev_ok     <= 1'b0;
      r.pol        <= `MSJ_RST_POL;
      r.settle     <= `MSJ_RST_W16;
      r.jog_freq   <= `MSJ_RST_W16;
      r.jsm        <= `MSJ_RST_JSM;
      r.spd0       <= `MSJ_RST_W16;
      r.fn         <= '0;
      r.spd        <= '0;
      r.tick_cnt   <= `MSJ_RST_W16;
      r.tick       <= 1'b0;
      r.bin_cand   <= 4'h0;
      r.settle_cnt <= `MSJ_RST_W16;
      r.bin_sel    <= 4'h0;
      r.st         <= ST_IDLE;
      r.stop       <= STOP_FREE;
      r.rdata      <= `MSJ_RST_W16;
      r.freq       <= `MSJ_RST_W16;
      r.run        <= 1'b0;
      r.rev        <= 1'b0;
      r.jog        <= 1'b0;
      r.frst       <= 1'b0;
      r.spd_idx    <= 4'h0;
    end else begin
      r <= next_r;
    end
  end

  assign RDATA_O       = r.rdata;
  assign FREQ_REF_O    = r.freq;
  assign RUN_O         = r.run;
  assign REVERSE_O     = r.rev;
  assign JOG_ACTIVE_O  = r.jog;
  assign STOP_METHOD_O = r.stop;
  assign FAULT_RESET_O = r.frst;
  assign SPEED_IDX_O   = r.spd_idx;

endmodule // msj_input_select

`default_nettype wire

// ==== inc/msj_defs.svh ====
// constants for the multispeed / jog input selection block
`ifndef MSJ_DEFS_SVH
`define MSJ_DEFS_SVH

// timing
`define MSJ_CLK_NS         20
`define MSJ_SETTLE_UNIT_NS 1000000

// register addresses (word index on the plain port)
`define MSJ_A_CTRL   6'h00
`define MSJ_A_POL    6'h01
`define MSJ_A_SETTLE 6'h02
`define MSJ_A_JOGF   6'h03
`define MSJ_A_JSM    6'h04
`define MSJ_A_SPD0   6'h05
`define MSJ_A_STAT   6'h06
`define MSJ_A_FREQ   6'h07
`define MSJ_A_FN_HI  3'h1
`define MSJ_A_SPD_HI 2'h1

// control and polarity register fields
`define MSJ_CTRL_MODE  0
`define MSJ_CTRL_SRC   1
`define MSJ_CTRL_REVOK 2
`define MSJ_POL_FWD    8

// field codes
`define MSJ_MODE_BINARY 1'b0
`define MSJ_MODE_BIT    1'b1
`define MSJ_FN_NONE     8'h00
`define MSJ_FN_BIN_SEL0 8'h02
`define MSJ_FN_JOG      8'h06
`define MSJ_FN_FRST     8'h12
`define MSJ_FN_BIT_SEL1 8'h20
`define MSJ_JSM_RUN_OK  3'h3
`define MSJ_JSM_MAX     3'h5
`define MSJ_JOG_MAX     16'h03E7
`define MSJ_FREQ_MAX    17'h0FFFF

// reset values
`define MSJ_RST_W16 16'h0000
`define MSJ_RST_POL 9'h000
`define MSJ_RST_JSM 3'h0

`endif

// ==== inc/msj_pkg.sv ====
// types for the multispeed / jog input selection block
`default_nettype none
package msj_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN  = 4'h2,
    ST_JOG  = 4'h4,
    ST_LOCK = 4'h8
  } msj_jog_e;

  typedef enum logic [1:0] {
    STOP_FREE  = 2'h0,
    STOP_DECEL = 2'h1,
    STOP_DCB   = 2'h2
  } msj_stop_e;

  typedef struct packed {
    logic             mode;
    logic             src_term;
    logic             rev_ok;
    logic [8:0]       pol;
    logic [15:0]      settle;
    logic [15:0]      jog_freq;
    logic [2:0]       jsm;
    logic [15:0]      spd0;
    logic [7:0][7:0]  fn;
    logic [14:0][15:0] spd;
    logic [15:0]      tick_cnt;
    logic             tick;
    logic [3:0]       bin_cand;
    logic [15:0]      settle_cnt;
    logic [3:0]       bin_sel;
    msj_jog_e         st;
    msj_stop_e        stop;
    logic [15:0]      rdata;
    logic [15:0]      freq;
    logic             run;
    logic             rev;
    logic             jog;
    logic             frst;
    logic [3:0]       spd_idx;
  } msj_state_s;

endpackage

`default_nettype wire

// ==== test/msj_input_select_chk.sv ====
// assertion checker for the multispeed / jog selection block
`timescale 1ns/1ps
`default_nettype none
`include "msj_defs.svh"
module msj_input_select_chk
  import msj_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic               CLK_I,
  input wire logic               RST_N_I,
  input wire logic               RD_I,
  input wire logic [15:0]        RDATA_O,
  input wire logic [7:0]         TERM_CLOSED_I,
  input wire logic               REV_RUN_I,
  input wire logic signed [15:0] ANALOG_MAIN_I,
  input wire logic signed [15:0] ANALOG_AUX_I,
  input wire logic [15:0]        FREQ_REF_O,
  input wire logic               RUN_O,
  input wire logic               REVERSE_O,
  input wire logic               JOG_ACTIVE_O,
  input wire logic [1:0]         STOP_METHOD_O,
  input wire logic               FAULT_RESET_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic signed [16:0] sum;
  assign sum = ANALOG_MAIN_I + ANALOG_AUX_I;
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data outside its slot");
  a_jog_cap: assert property (JOG_ACTIVE_O |-> FREQ_REF_O <= `MSJ_JOG_MAX)
    else $error("jog reference above limit");
  a_jog_run: assert property (JOG_ACTIVE_O |-> RUN_O)
    else $error("jogging without run");
  a_stop_code: assert property (STOP_METHOD_O != 2'h3)
    else $error("illegal stop method");
  a_frst_open: assert property ($past(RST_N_I) && $past(TERM_CLOSED_I) == 8'h00
    |-> !FAULT_RESET_O)
    else $error("fault reset with all contacts open");
  a_rev_plain: assert property ($past(RST_N_I) && $past(sum) >= 0
    |-> REVERSE_O == $past(REV_RUN_I))
    else $error("direction flipped without negative sum");
  a_stop_hold: assert property (RUN_O && $past(RUN_O) |-> $stable(STOP_METHOD_O))
    else $error("stop method changed while running");
  a_plain_stop: assert property ($fell(RUN_O) && !$past(JOG_ACTIVE_O)
    |-> STOP_METHOD_O == 2'h1)
    else $error("normal stop not decel");
endmodule // msj_input_select_chk

bind msj_input_select msj_input_select_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .TERM_CLOSED_I(TERM_CLOSED_I), .REV_RUN_I(REV_RUN_I),
  .ANALOG_MAIN_I(ANALOG_MAIN_I), .ANALOG_AUX_I(ANALOG_AUX_I),
  .FREQ_REF_O(FREQ_REF_O), .RUN_O(RUN_O), .REVERSE_O(REVERSE_O),
  .JOG_ACTIVE_O(JOG_ACTIVE_O), .STOP_METHOD_O(STOP_METHOD_O),
  .FAULT_RESET_O(FAULT_RESET_O));
`default_nettype wire

// ==== test/msj_switch_model.sv ====
// contact model of the switches wired to the input terminals
`timescale 1ns/1ps
`default_nettype none
module msj_switch_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [8:0] req_i,
  input  wire logic       bounce_i,
  output logic      [8:0] contact_o
);
  logic [8:0] settled;
  logic [2:0] cnt;
  // chatter only when asked: old and new level alternate for four cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      contact_o <= 9'h000;
      settled <= 9'h000;
      cnt <= 3'h0;
    end else if (req_i != settled) begin
      if (!bounce_i || cnt == 3'h4) begin
        contact_o <= req_i;
        settled <= req_i;
        cnt <= 3'h0;
      end else begin
        contact_o <= cnt[0] ? settled : req_i;
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule // msj_switch_model
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the multispeed / jog selection block
`timescale 1ns/1ps
`default_nettype none
`include "msj_defs.svh"
module tb_top;
  import msj_pkg::*;
  logic clk, rst_n, wr, rd, rd_d, rev_run, fwd_req, bounce, fwd;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, rnd, pol;
  logic [7:0] term_req, term, eff;
  logic signed [15:0] a_main, a_aux;
  logic [15:0] spd [16];
  logic [15:0] expq [$];
  logic [5:0] adq [$];
  logic [15:0] freq_o, ev;
  logic [5:0] ea;
  logic [3:0] idx_o;
  logic [1:0] stop_o;
  logic run_o, rev_o, jog_o, frst_o;
  logic [3:0] idx;
  logic [1:0] stp;
  int err_total, n_checks, cyc, i, k, m;

  msj_switch_model SW (.clk_i(clk), .rst_n_i(rst_n), .req_i({fwd_req, term_req}),
    .bounce_i(bounce), .contact_o({fwd, term}));
  msj_input_select #(.TICK_CYCLES(4)) DUT (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TERM_CLOSED_I(term),
    .FWD_CLOSED_I(fwd), .REV_RUN_I(rev_run), .MOTOR_RUNNING_I(1'b0),
    .ANALOG_MAIN_I(a_main), .ANALOG_AUX_I(a_aux), .FREQ_REF_O(freq_o), .RUN_O(run_o),
    .REVERSE_O(rev_o), .JOG_ACTIVE_O(jog_o), .STOP_METHOD_O(stop_o),
    .FAULT_RESET_O(frst_o), .SPEED_IDX_O(idx_o));

  // ---------------------------
  // helpers
  // ---------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] stw(input logic fr, run, dir, jogging, input logic [1:0] sp,
                                      input logic [3:0] ix, bs);
    return {2'h0, bs, ix, sp, jogging, dir, run, fr};
  endfunction
  task wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    adq.push_back(a);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task term_set(input logic [7:0] t, input logic f, input logic b, input int w);
    @(posedge clk);
    term_req <= t;
    fwd_req <= f;
    bounce <= b;
    repeat (w) @(posedge clk);
  endtask
  task chk_rd(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t pins %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) rd_d <= rd;
  // pins are compared with the status word of the same read; inputs hold still around reads
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      ea = adq.pop_front();
      ev = expq.pop_front();
      chk_rd(rdata, ev);
      if (ea == `MSJ_A_STAT) begin
        chk_pin({6'h00, idx_o, stop_o, jog_o, rev_o, run_o, frst_o}, {6'h00, ev[9:0]});
      end
      if (ea == `MSJ_A_FREQ) begin
        chk_pin(freq_o, ev);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end

  // ---------------------------
  // scenarios
  // ---------------------------
  initial begin
    {rst_n, wr, rd, rev_run, fwd_req, bounce, addr, wdata, term_req} = '0;
    {a_main, a_aux, stp} = '0;
    rnd = 16'h0049;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`MSJ_A_CTRL, 16'h0000);
    rd_reg(`MSJ_A_POL, 16'h0000);
    rd_reg(`MSJ_A_JSM, 16'h0000);
    rd_reg(6'h10, 16'h0000);
    wr_reg(`MSJ_A_JOGF, 16'h03E8);
    rd_reg(`MSJ_A_JOGF, `MSJ_JOG_MAX);
    // bit mode: terminal 1 fault reset, terminals 2..8 speeds 1..7
    wr_reg(`MSJ_A_CTRL, 16'h0001);
    wr_reg({`MSJ_A_FN_HI, 3'h0}, 16'(`MSJ_FN_FRST));
    for (i = 1; i < 8; i++) begin
      wr_reg({`MSJ_A_FN_HI, 3'(i)}, 16'(`MSJ_FN_BIT_SEL1 + i - 1));
    end
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      spd[i] = rnd & 16'h7FFF;
      wr_reg(i == 0 ? `MSJ_A_SPD0 : {`MSJ_A_SPD_HI, 4'(i)}, spd[i]);
    end
    for (m = 0; m < 12; m++) begin
      rnd = lfsr(rnd);
      pol = {7'h00, 1'b0, rnd[7:0]};
      wr_reg(`MSJ_A_POL, pol);
      rnd = lfsr(rnd);
      a_main <= rnd;
      a_aux <= lfsr(rnd);
      term_set(rnd[15:8], 1'b1, 1'b0, 4);
      eff = rnd[15:8] ^ pol[7:0];
      idx = 4'h0;
      for (k = 7; k >= 1; k--) if (eff[k]) idx = 4'(k);
      rd_reg(`MSJ_A_STAT, stw(rnd[8], 1'b1, 1'b0, 1'b0, stp, idx, 4'h0));
      rd_reg(`MSJ_A_FREQ, spd[idx]);
    end
    // binary mode, terminals 2..5 carry the four selection inputs
    wr_reg(`MSJ_A_CTRL, 16'h0000);
    wr_reg(`MSJ_A_POL, 16'h0000);
    for (i = 1; i < 8; i++) begin
      wr_reg({`MSJ_A_FN_HI, 3'(i)}, i < 5 ? 16'(`MSJ_FN_BIN_SEL0 + i - 1) : 16'h0000);
    end
    for (i = 0; i < 16; i++) begin
      term_set({3'h0, 4'(i), 1'b0}, 1'b1, 1'b0, 8);
      rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, 1'b0, stp, 4'(i), 4'(i)));
      rd_reg(`MSJ_A_FREQ, spd[i]);
    end
    // long settle delay: a short glitch and chatter are not taken
    wr_reg(`MSJ_A_SETTLE, 16'h0003);
    term_set(8'h0A, 1'b1, 1'b0, 3);
    term_set(8'h1E, 1'b1, 1'b0, 30);
    rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, 1'b0, stp, 4'hF, 4'hF));
    term_set(8'h0C, 1'b1, 1'b1, 6);
    rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, 1'b0, stp, 4'hF, 4'hF));
    repeat (30) @(posedge clk);
    rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, 1'b0, stp, 4'h6, 4'h6));
    // terminal source, reversible analog, negative sum
    wr_reg(`MSJ_A_SETTLE, 16'h0000);
    wr_reg(`MSJ_A_CTRL, 16'h0006);
    a_main <= -16'sd300;
    a_aux <= 16'sd100;
    term_set(8'h00, 1'b1, 1'b0, 8);
    rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b1, 1'b0, stp, 4'h0, 4'h0));
    rd_reg(`MSJ_A_FREQ, 16'h00C8);
    rev_run <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, 1'b0, stp, 4'h0, 4'h0));
    rev_run <= 1'b0;
    // jog on terminal 6 through every stop mode
    wr_reg(`MSJ_A_CTRL, 16'h0000);
    wr_reg({`MSJ_A_FN_HI, 3'h5}, 16'(`MSJ_FN_JOG));
    wr_reg(`MSJ_A_JOGF, 16'h0123);
    term_set(8'h00, 1'b0, 1'b0, 6);
    stp = 2'h1;
    rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b0, 1'b0, 1'b0, stp, 4'h0, 4'h0));
    for (m = 0; m < 6; m++) begin
      wr_reg(`MSJ_A_JSM, 16'(m));
      term_set(8'h20, 1'b0, 1'b0, 4);
      term_set(8'h20, 1'b1, 1'b0, 4);
      rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, 1'b1, stp, 4'h0, 4'h0));
      rd_reg(`MSJ_A_FREQ, 16'h0123);
      term_set(8'h20, 1'b0, 1'b0, 4);
      stp = 2'(m % 3);
      rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b0, 1'b0, 1'b0, stp, 4'h0, 4'h0));
      term_set(8'h00, 1'b0, 1'b0, 4);
      term_set(8'h00, 1'b1, 1'b0, 4);
      term_set(8'h20, 1'b1, 1'b0, 4);
      rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b1, 1'b0, m > 2, stp, 4'h0, 4'h0));
      term_set(8'h00, 1'b1, 1'b0, 4);
      if (m > 2) stp = 2'h0;
      rd_reg(`MSJ_A_STAT, stw(1'b0, m < 3, 1'b0, 1'b0, stp, 4'h0, 4'h0));
      term_set(8'h00, 1'b0, 1'b0, 4);
      if (m < 3) stp = 2'h1;
      rd_reg(`MSJ_A_STAT, stw(1'b0, 1'b0, 1'b0, 1'b0, stp, 4'h0, 4'h0));
    end
    repeat (3) @(posedge clk);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
